/* inc/cbuf_pkg.sv */
// Package for the circular buffer address generation block
package cbuf_pkg;
  localparam int ADDR_W         = 16;              // Data address width
  localparam int SEL_W          = 4;               // Pointer select field width
  localparam int XSEL_LSB       = 0;               // X select field position
  localparam int YSEL_LSB       = 4;               // Y select field position
  localparam int XEN_BIT        = 15;              // X wrap enable position
  localparam int YEN_BIT        = 14;              // Y wrap enable position
  localparam logic [3:0]  SEL_NONE  = 4'hF;        // Select code meaning off
  localparam logic [15:0] CTRL_RST  = 16'h0000;    // Control reset value
  localparam logic [15:0] ADDR_RST  = 16'h0000;    // Boundary reset value

  // Pointer update request from the pipeline
  typedef struct packed {
    logic              valid;                      // Update present
    logic [SEL_W-1:0]  reg_num;                    // Working register number
    logic [ADDR_W-1:0] old_ptr;                    // Pointer before update
    logic [ADDR_W-1:0] new_ptr;                    // Pointer after plain math
  } cbuf_upd_t;

  // Pointer update result to the register file
  typedef struct packed {
    logic              valid;                      // Result present
    logic [SEL_W-1:0]  reg_num;                    // Working register number
    logic [ADDR_W-1:0] ptr;                        // Final pointer
    logic              wrapped;                    // Boundary reload taken
  } cbuf_res_t;

  // Buffer boundary pair
  typedef struct packed {
    logic [ADDR_W-1:0] start_addr;                 // Lowest buffer address
    logic [ADDR_W-1:0] end_addr;                   // Highest buffer address
  } cbuf_bounds_t;
endpackage

/* rtl/cbuf_wrap.sv */
// One boundary-checking unit for a single address generator
`timescale 1ns/1ps
module cbuf_wrap
  import cbuf_pkg::*;
#(
  parameter int AW = 16                            // Address width
)
(
  input  wire logic                   active,
  input  wire logic                   word_only,
  input  wire logic [3:0]             sel,
  input  wire cbuf_pkg::cbuf_bounds_t bounds,
  input  wire cbuf_pkg::cbuf_upd_t    upd,
  output cbuf_pkg::cbuf_res_t         res
);
  import cbuf_pkg::*;

  logic hit;                                       // Update targets selected pointer
  logic inc;                                       // Pointer moves upward
  logic over;                                      // Moved past end address
  logic under;                                     // Moved below start address
  logic [AW-1:0] ptr;                              // Chosen pointer

  // Boundary decision, purely combinational so the pipeline sees no latency
  always_comb
  begin
    hit   = active && (upd.reg_num == sel);
    inc   = upd.new_ptr > upd.old_ptr;
    // Only the edge ahead of the motion is checked; software keeps non power-of-two buffers one-way
    over  = inc && (upd.new_ptr > bounds.end_addr);
    under = !inc && (upd.new_ptr < bounds.start_addr);
    if (!hit)
    begin
      ptr = upd.new_ptr;
    end
    else if (over)
    begin
      ptr = bounds.start_addr;
    end
    else if (under)
    begin
      ptr = bounds.end_addr;
    end
    else
    begin
      ptr = upd.new_ptr;
    end
    // Y side assumes word data, so bit 0 of the selected pointer is forced clear
    if (word_only && hit)
    begin
      ptr[0] = 1'b0;
    end
    res.valid   = upd.valid;
    res.reg_num = upd.reg_num;
    res.ptr     = ptr;
    res.wrapped = hit && (over || under);
  end
endmodule

/* rtl/cbuf_addr_gen.sv */
// Circular buffer address generation for the X and Y data spaces
// Usage notes
// Load both boundaries before setting an enable bit.
// Boundaries are byte addresses, both ends inclusive.
// Writes take effect at the next clock edge.
// Boundary writes may land in any order, back to back.
// The X read and X write generators share one select.
// Select code fifteen switches a space off entirely.
// Selecting the frame or stack pointer is best avoided.
// Non power-of-two buffers must be walked one way only.
// Direction is taken from an unsigned compare of new and old pointer.
// Only the boundary ahead of the motion is checked.
// A pointer stepping up through zero counts as a decrement, down through zero as an increment.
// Lengths read back as end minus start, in bytes.
// Lengths come from flops; results are combinational.
// Results follow the updates in the same cycle.
// Y results for the selected pointer land on an even byte address while the Y space is active.
// Reset clears every boundary and turns both spaces off.
`timescale 1ns/1ps
module cbuf_addr_gen
  import cbuf_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // Control word and boundary writes
  input  wire logic                ctrl_we,
  input  wire logic [15:0]         ctrl_wdata,
  input  wire logic                bounds_we,
  input  wire logic [1:0]          bounds_sel,
  input  wire logic [15:0]         bounds_wdata,
  // Pointer updates from the pipeline
  input  wire cbuf_pkg::cbuf_upd_t x_read_upd,
  input  wire cbuf_pkg::cbuf_upd_t x_write_upd,
  input  wire cbuf_pkg::cbuf_upd_t y_upd,
  // Final pointers to the register file
  output cbuf_pkg::cbuf_res_t      x_read_res,
  output cbuf_pkg::cbuf_res_t      x_write_res,
  output cbuf_pkg::cbuf_res_t      y_res,
  // Status readback
  output logic [15:0]              circular_addr_control,
  output logic                     x_active,
  output logic                     y_active,
  output logic [15:0]              x_buffer_length,
  output logic [15:0]              y_buffer_length
);
  import cbuf_pkg::*;

  // Registers
  logic [15:0]  ctrl_q;                            // Control word
  cbuf_bounds_t x_bounds_q;                        // X buffer boundaries
  cbuf_bounds_t x_bounds_d;                        // X boundaries after this edge
  cbuf_bounds_t y_bounds_q;                        // Y buffer boundaries
  cbuf_bounds_t y_bounds_d;                        // Y boundaries after this edge
  logic [15:0]  x_len_q;                           // X length, held in a flop
  logic [15:0]  y_len_q;                           // Y length, held in a flop
  // Decoded fields
  logic [3:0]   x_pointer_select;                  // X pointer field
  logic [3:0]   y_pointer_select;                  // Y pointer field
  logic         x_wrap_enable;                     // X enable flag
  logic         y_wrap_enable;                     // Y enable flag

  // Length in bytes minus one: end minus start, stored in x_len_q and y_len_q
  function automatic logic [15:0] buf_len(input cbuf_bounds_t b);
    buf_len = b.end_addr - b.start_addr;
  endfunction

  // One space's pointer select field out of the control word
  function automatic logic [SEL_W-1:0] sel_field(input logic [15:0] c, input int lsb);
    sel_field = c[lsb +: SEL_W];
  endfunction

  // A space wraps only when enabled and its select is not the off code
  function automatic logic space_on(input logic en, input logic [SEL_W-1:0] sel);
    space_on = en && (sel != SEL_NONE);
  endfunction

  // Control register write
  // A write shows in the results from the next cycle on
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrl_q <= CTRL_RST;
    end
    else if (ctrl_we)
    begin
      ctrl_q <= ctrl_wdata;
    end
  end

  // Boundary write decode, 0..3 = X start, X end, Y start, Y end
  always_comb
  begin
    x_bounds_d = x_bounds_q;                       // Hold unless written
    y_bounds_d = y_bounds_q;
    if (bounds_we)
    begin
      unique case (bounds_sel)
        2'h0: x_bounds_d.start_addr = bounds_wdata;
        2'h1: x_bounds_d.end_addr   = bounds_wdata;
        2'h2: y_bounds_d.start_addr = bounds_wdata;
        2'h3: y_bounds_d.end_addr   = bounds_wdata;
      endcase
    end
  end

  // X boundary registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      x_bounds_q <= {ADDR_RST, ADDR_RST};
    end
    else
    begin
      x_bounds_q <= x_bounds_d;
    end
  end

  // Y boundary registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      y_bounds_q <= {ADDR_RST, ADDR_RST};
    end
    else
    begin
      y_bounds_q <= y_bounds_d;
    end
  end

  // Lengths kept in flops, worked out from the values about to be stored
  // so they change at the same edge as the boundary write itself
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      x_len_q <= buf_len({ADDR_RST, ADDR_RST});
      y_len_q <= buf_len({ADDR_RST, ADDR_RST});
    end
    else
    begin
      x_len_q <= buf_len(x_bounds_d);
      y_len_q <= buf_len(y_bounds_d);
    end
  end

  // Field decode and activation; X read and X write share one decision
  always_comb
  begin
    x_pointer_select = sel_field(ctrl_q, XSEL_LSB);
    y_pointer_select = sel_field(ctrl_q, YSEL_LSB);
    x_wrap_enable    = ctrl_q[XEN_BIT];
    y_wrap_enable    = ctrl_q[YEN_BIT];
    x_active = space_on(x_wrap_enable, x_pointer_select);
    y_active = space_on(y_wrap_enable, y_pointer_select);
  end

  // Readback and lengths straight from flops
  assign circular_addr_control = ctrl_q;
  assign x_buffer_length       = x_len_q;
  assign y_buffer_length       = y_len_q;

  // Three generators work side by side in one cycle. Each sees only its
  // own update, so a register updated on two ports at once is judged
  // once per port; the pipeline decides which result it keeps.

  // X read generator; also serves program space pointers
  // Byte data allowed, so bit 0 is left alone
  cbuf_wrap #(.AW(ADDR_W)) u_x_read (
    .active    (x_active),
    .word_only (1'b0),
    .sel       (x_pointer_select),
    .bounds    (x_bounds_q),
    .upd       (x_read_upd),
    .res       (x_read_res)
  );

  // X write generator shares X settings
  // Same select and buffer as the read side
  cbuf_wrap #(.AW(ADDR_W)) u_x_write (
    .active    (x_active),
    .word_only (1'b0),
    .sel       (x_pointer_select),
    .bounds    (x_bounds_q),
    .upd       (x_write_upd),
    .res       (x_write_res)
  );

  // Y generator, word data only
  // Bit 0 cleared on the selected pointer only
  cbuf_wrap #(.AW(ADDR_W)) u_y (
    .active    (y_active),
    .word_only (1'b1),
    .sel       (y_pointer_select),
    .bounds    (y_bounds_q),
    .upd       (y_upd),
    .res       (y_res)
  );
endmodule

/* test/cbuf_chk.sv */
// Port checker for the circular buffer address generator
`timescale 1ns/1ps
module cbuf_chk
  import cbuf_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                ctrl_we,
  input  wire logic [15:0]         ctrl_wdata,
  input  wire logic                bounds_we,
  input  wire logic [1:0]          bounds_sel,
  input  wire logic [15:0]         bounds_wdata,
  input  wire cbuf_pkg::cbuf_upd_t x_read_upd,
  input  wire cbuf_pkg::cbuf_upd_t y_upd,
  input  wire cbuf_pkg::cbuf_res_t x_read_res,
  input  wire cbuf_pkg::cbuf_res_t y_res,
  input  wire logic [15:0]         circular_addr_control,
  input  wire logic                x_active,
  input  wire logic                y_active,
  input  wire logic [15:0]         x_buffer_length
);
  logic [15:0] bnd_q [4];  // Shadow boundaries, reset like the design
  logic [3:0]  xs;         // X select field
  logic [3:0]  ys;         // Y select field
  logic [15:0] xn;         // X read new pointer
  assign xs = circular_addr_control[3:0];
  assign ys = circular_addr_control[7:4];
  assign xn = x_read_upd.new_ptr;
  // Shadow copy so wrap targets are judged from the writes alone
  always_ff @(posedge sys_clk)
    if (reset) bnd_q <= '{default: 16'h0000};
    else if (bounds_we) bnd_q[bounds_sel] <= bounds_wdata;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_ctl; ctrl_we |=> circular_addr_control == $past(ctrl_wdata); endproperty
  a_ctl: assert property (p_ctl) else $error("control write lost");
  property p_xon; x_active == (xs != SEL_NONE && circular_addr_control[15]); endproperty
  a_xon: assert property (p_xon) else $error("x active wrong");
  property p_yon; y_active == (ys != SEL_NONE && circular_addr_control[14]); endproperty
  a_yon: assert property (p_yon) else $error("y active wrong");
  property p_len; bounds_we |=> x_buffer_length == 16'(bnd_q[1] - bnd_q[0]); endproperty
  a_len: assert property (p_len) else $error("length wrong");
  property p_ovr; x_active && x_read_upd.reg_num == xs && xn > x_read_upd.old_ptr
    && xn > bnd_q[1] |-> x_read_res.wrapped && x_read_res.ptr == bnd_q[0]; endproperty
  a_ovr: assert property (p_ovr) else $error("no reload to start");
  property p_und; x_active && x_read_upd.reg_num == xs && xn < x_read_upd.old_ptr
    && xn < bnd_q[0] |-> x_read_res.wrapped && x_read_res.ptr == bnd_q[1]; endproperty
  a_und: assert property (p_und) else $error("no reload to end");
  property p_pas; !x_active || x_read_upd.reg_num != xs |-> x_read_res.ptr == xn; endproperty
  a_pas: assert property (p_pas) else $error("pointer altered");
  property p_yb0; y_active && y_upd.reg_num == ys |-> !y_res.ptr[0]; endproperty
  a_yb0: assert property (p_yb0) else $error("y bit zero set");
endmodule

bind cbuf_addr_gen cbuf_chk u_chk (.*);

/* test/cbuf_pipe_model.sv */
// Pipeline model: issues one post-modify pointer update
`timescale 1ns/1ps
module cbuf_pipe_model
  import cbuf_pkg::*;
(
  input  wire logic [3:0]     rn,
  input  wire logic [15:0]    ptr,
  input  wire logic [15:0]    step,
  output cbuf_pkg::cbuf_upd_t upd
);
  // Plain pointer math; the wrap is left to the block
  assign upd = {1'b1, rn, ptr, 16'(ptr + step)};
endmodule

/* test/cbuf_addr_gen_tb_top.sv */
// Testbench for the circular buffer address generator
`timescale 1ns/1ps
module cbuf_addr_gen_tb_top;
  import cbuf_pkg::*;
  logic        sys_clk, reset, ctrl_we, bounds_we, x_active, y_active;
  logic [1:0]  bounds_sel;
  logic [15:0] ctrl_wdata, bounds_wdata, ctl, bx [4], op [3], st [3];
  logic [15:0] circular_addr_control, x_buffer_length, y_buffer_length;
  logic [3:0]  rn [3];
  logic [16:0] len;
  cbuf_upd_t   u [3];
  cbuf_res_t   r [3];
  int          err_total, checks, k;
  cbuf_pipe_model m0 (.rn(rn[0]), .ptr(op[0]), .step(st[0]), .upd(u[0]));
  cbuf_pipe_model m1 (.rn(rn[1]), .ptr(op[1]), .step(st[1]), .upd(u[1]));
  cbuf_pipe_model m2 (.rn(rn[2]), .ptr(op[2]), .step(st[2]), .upd(u[2]));
  cbuf_addr_gen dut (.sys_clk(sys_clk), .reset(reset), .ctrl_we(ctrl_we),
    .ctrl_wdata(ctrl_wdata), .bounds_we(bounds_we), .bounds_sel(bounds_sel),
    .bounds_wdata(bounds_wdata), .x_read_upd(u[0]), .x_write_upd(u[1]), .y_upd(u[2]),
    .x_read_res(r[0]), .x_write_res(r[1]), .y_res(r[2]), .x_active(x_active),
    .circular_addr_control(circular_addr_control), .y_active(y_active),
    .x_buffer_length(x_buffer_length), .y_buffer_length(y_buffer_length));
  always #2.5 sys_clk = ~sys_clk;
  // Expected {wrapped, ptr} of channel i (0 X read, 1 X write, 2 Y)
  function automatic logic [16:0] exp_f(input logic [1:0] i);
    logic        hit, w;
    logic [3:0]  sl;
    logic [15:0] n, p;
    sl = i[1] ? ctl[7:4] : ctl[3:0];
    hit = ctl[15 - i[1]] && sl != 4'hF && rn[i] == sl;
    n = op[i] + st[i];
    w = hit && ((n > op[i] && n > bx[{i[1], 1'b1}]) || (n < op[i] && n < bx[{i[1], 1'b0}]));
    p = w ? bx[{i[1], !(n > op[i])}] : n;
    p[0] = p[0] & ~(hit & i[1]);
    return {w, p};
  endfunction
  // Select code that never names the frame or stack pointer
  function automatic logic [3:0] pick();
    logic [3:0] t;
    t = 4'($urandom % 15);
    return t == 4'hE ? 4'hF : t;
  endfunction
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) err_total++;
    if (got !== exp) $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  // Strobe held one full cycle, then a gap before the next write
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(negedge sys_clk);
    {ctrl_we, bounds_we, bounds_sel, ctrl_wdata, bounds_wdata} = {a[2], !a[2], a[1:0], v, v};
    ctl = a[2] ? v : ctl;
    if (!a[2]) bx[a[1:0]] = v;
    @(negedge sys_clk);
    {ctrl_we, bounds_we} = 2'b00;
  endtask
  task automatic chk_all();
    #1;
    for (int i = 0; i < 3; i++)
    begin
      chk({r[i].wrapped, r[i].ptr}, exp_f(i[1:0]));
      chk({r[i].valid, r[i].reg_num}, {1'b1, rn[i]});
    end
    chk(x_active, ctl[15] && ctl[3:0] != 4'hF);
    chk(y_active, ctl[14] && ctl[7:4] != 4'hF);
    chk(x_buffer_length, 16'(bx[1] - bx[0]));
    chk(y_buffer_length, 16'(bx[3] - bx[2]));
    chk(circular_addr_control, ctl);
  endtask
  task automatic give_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    {sys_clk, ctrl_we, bounds_we, bounds_sel, ctrl_wdata, bounds_wdata, ctl} = '0;
    {reset, err_total, checks} = {1'b1, 32'd0, 32'd0};
    bx = '{default: 16'h0000};
    rn = '{default: 4'h1};
    op = '{16'h1162, 16'h1100, 16'h1162};
    st = '{16'h0002, 16'hFFFE, 16'h0002};
    void'($urandom(20782));
    repeat (3) @(negedge sys_clk);
    reset = 0;
    chk_all();
    $display("reset test done");
    wr(3'h0, 16'h1100);
    wr(3'h1, 16'h1163);
    wr(3'h4, 16'h8001);
    chk_all();
    $display("walk test done");
    // Code 14 is stepped over, it would name the frame pointer
    for (k = 0; k < 16; k += (k == 13) ? 2 : 1)
    begin
      wr(3'h4, {k[0], k[1], 6'h00, k[3:0], k[3:0]});
      rn = '{default: k[3:0]};
      chk_all();
    end
    $display("select test done");
    @(negedge sys_clk);
    reset = 1;
    repeat (3) @(negedge sys_clk);
    reset = 0;
    ctl = '0;
    bx = '{default: 16'h0000};
    chk_all();
    $display("second reset test done");
    for (k = 0; k < 300; k++)
    begin
      for (int b = 0; b < 4; b += 2)
      begin
        len = 17'h1 << (1 + $urandom % 16);
        wr(b[2:0], 16'($urandom) & ~16'(len - 1));
        wr(b[2:0] + 3'h1, 16'(bx[b] + len - 1));
      end
      wr(3'h4, {2'($urandom), 6'h00, pick(), pick()});
      for (int i = 0; i < 3; i++)
      begin
        len = 17'h1 + bx[i[1] * 2 + 1] - bx[i[1] * 2];
        rn[i] = $urandom % 2 ? (i[1] ? ctl[7:4] : ctl[3:0]) : 4'($urandom);
        op[i] = 16'(bx[i[1] * 2] + ($urandom & (len - 1))) & 16'hFFFE;
        st[i] = $urandom % 2 ? 16'h0002 : 16'hFFFE;
      end
      chk_all();
    end
    $display("random test done");
    give_verdict();
  end
endmodule
